/* logic/scs_pkg.sv */
package scs_pkg;
  localparam int unsigned DATA_W        = 32;
  localparam int unsigned ADDR_W        = 8;
  // register byte offsets
  localparam logic [7:0]  SYS_CFG_OFS   = 8'h00;
  localparam logic [7:0]  LOOP_CFG_OFS  = 8'h04;
  localparam logic [7:0]  PRESC_OFS     = 8'h08;
  localparam logic [7:0]  STATUS_OFS    = 8'h0C;
  // clock_source_select codes
  localparam logic [1:0]  SEL_WAKE      = 2'h0;
  localparam logic [1:0]  SEL_LOOP      = 2'h2;
  localparam logic [1:0]  SEL_DIRECT    = 2'h3;
  // loop_config_reg fields
  localparam int unsigned BYPASS_POS    = 0;
  localparam int unsigned OSC_SRC_POS   = 1;
  localparam int unsigned LOOP_INPUT_DIVIDER_FIELD_LSB      = 4;
  localparam int unsigned LOOP_INPUT_DIVIDER_FIELD_W        = 4;
  localparam int unsigned LOOP_FEEDBACK_FACTOR_FIELD_LSB      = 8;
  localparam int unsigned LOOP_FEEDBACK_FACTOR_FIELD_W        = 8;
  localparam int unsigned LOOP_OUTPUT_DIVIDER_FIELD_LSB     = 16;
  localparam int unsigned LOOP_OUTPUT_DIVIDER_FIELD_W       = 7;
  // prescaler_divider_field, factor 1..1024
  localparam int unsigned PRESCALER_DIVIDER_FIELD_W       = 10;
  localparam int unsigned K1_FACT_W     = PRESCALER_DIVIDER_FIELD_W + 1;
  localparam logic [K1_FACT_W-1:0] K1_FACT_MAX = 11'h400;
  // reset values
  localparam logic [1:0]  SEL_RST       = 2'h0;
  localparam logic        BYPASS_RST    = 1'h1;
  localparam logic        OSC_SRC_RST   = 1'h0;
  localparam logic [LOOP_INPUT_DIVIDER_FIELD_W-1:0]  LOOP_INPUT_DIVIDER_FIELD_RST  = 4'h0;
  localparam logic [LOOP_FEEDBACK_FACTOR_FIELD_W-1:0]  LOOP_FEEDBACK_FACTOR_FIELD_RST  = 8'h0;
  localparam logic [LOOP_OUTPUT_DIVIDER_FIELD_W-1:0] LOOP_OUTPUT_DIVIDER_FIELD_RST = 7'h0;
  localparam logic [PRESCALER_DIVIDER_FIELD_W-1:0] PRESCALER_DIVIDER_FIELD_RST = 10'h000;

  typedef enum logic [3:0] {
    MODE_WAKE   = 4'h1,
    MODE_LOOP   = 4'h2,
    MODE_PRESC  = 4'h4,
    MODE_DIRECT = 4'h8
  } scs_mode_t;
endpackage

/* logic/scs_top.sv */
`timescale 1ns/100ps
// Operation
// - select code 11 passes the direct clock input unchanged as system clock
// - select code 10 with bypass set runs oscillator through the prescaler
// - prescaler input is the crystal pin or the internal source, as configured
// - prescaler factor is the divider field value plus one
// - factor one passes oscillator through, keeping its duty cycle
// - largest factor divides the oscillator by 1024
// - crystal bypass with factor one behaves like direct drive
// - select code 10 with bypass clear enables the loop and uses its output
// - loop factors are feedback, input and output divider fields plus one
// - select code 00 runs the system clock from the wakeup oscillator
module scs_top (
  input  wire logic                     clk_i,
  input  wire logic                     sys_rst_i,
  input  wire logic [7:0]               addr_i,
  input  wire logic [31:0]              wr_data_i,
  input  wire logic                     wr_i,
  input  wire logic                     rd_i,
  output logic      [31:0]              rd_data_o,
  input  wire logic                     direct_clock_i,
  input  wire logic                     crystal_input_pin_i,
  input  wire logic                     internal_osc_i,
  input  wire logic                     wakeup_osc_i,
  input  wire logic                     loop_clk_i,
  output logic                          sys_clk_o,
  output logic                          loop_enable_o,
  output logic      [4:0]               loop_input_div_o,
  output logic      [8:0]               loop_feedback_o,
  output logic      [7:0]               loop_output_div_o
);
  localparam int unsigned K1_FACT_W = scs_pkg::K1_FACT_W;
  localparam int unsigned PRESCALER_DIVIDER_FIELD_W   = scs_pkg::PRESCALER_DIVIDER_FIELD_W;

  function automatic logic [K1_FACT_W-1:0] plus_one(input logic [PRESCALER_DIVIDER_FIELD_W-1:0] f);
    plus_one = {1'b0, f} + 11'h001;
  endfunction

  logic [1:0]                    sel_q;
  logic                          bypass_q;
  logic                          osc_src_q;
  logic [scs_pkg::LOOP_INPUT_DIVIDER_FIELD_W-1:0]    loop_input_divider_field_q;
  logic [scs_pkg::LOOP_FEEDBACK_FACTOR_FIELD_W-1:0]    loop_feedback_factor_field_q;
  logic [scs_pkg::LOOP_OUTPUT_DIVIDER_FIELD_W-1:0]   loop_output_divider_field_q;
  logic [PRESCALER_DIVIDER_FIELD_W-1:0]            prescaler_divider_field_q;
  scs_pkg::scs_mode_t            mode_q;
  scs_pkg::scs_mode_t            mode_d;
  logic [PRESCALER_DIVIDER_FIELD_W-1:0]            cnt_q;
  logic [PRESCALER_DIVIDER_FIELD_W-1:0]            cnt_d;
  logic                          osc_prev_q;
  logic                          sys_clk_d;

  wire        wr_sys    = wr_i && (addr_i == scs_pkg::SYS_CFG_OFS);
  wire        wr_loop   = wr_i && (addr_i == scs_pkg::LOOP_CFG_OFS);
  wire        wr_presc  = wr_i && (addr_i == scs_pkg::PRESC_OFS);
  wire        osc_lvl   = osc_src_q ? internal_osc_i : crystal_input_pin_i;
  wire        osc_rise  = osc_lvl && !osc_prev_q;
  wire [K1_FACT_W-1:0] k1_fact = plus_one(prescaler_divider_field_q);
  wire [PRESCALER_DIVIDER_FIELD_W-1:0]   k1_half = (prescaler_divider_field_q >> 1) + 10'h001;
  wire        div_high  = (cnt_q < k1_half);

  // mode decode; code 01 is unassigned and falls back to wakeup
  assign mode_d = (sel_q == scs_pkg::SEL_DIRECT) ? scs_pkg::MODE_DIRECT :
                  (sel_q == scs_pkg::SEL_LOOP && bypass_q) ? scs_pkg::MODE_PRESC :
                  (sel_q == scs_pkg::SEL_LOOP) ? scs_pkg::MODE_LOOP :
                  scs_pkg::MODE_WAKE;

  // divider wraps at the factor; count only advances on oscillator edges
  assign cnt_d = !osc_rise ? cnt_q :
                 (cnt_q >= prescaler_divider_field_q) ? 10'h000 : cnt_q + 10'h001;

  always_comb begin
    case (mode_q)
      scs_pkg::MODE_DIRECT: sys_clk_d = direct_clock_i;
      scs_pkg::MODE_PRESC:  sys_clk_d = (prescaler_divider_field_q == 10'h000) ? osc_lvl : div_high;
      scs_pkg::MODE_LOOP:   sys_clk_d = loop_clk_i;
      scs_pkg::MODE_WAKE:   sys_clk_d = wakeup_osc_i;
      default:              sys_clk_d = wakeup_osc_i;
    endcase
  end

  wire [31:0] rd_mux =
    (addr_i == scs_pkg::SYS_CFG_OFS)  ? {30'h0, sel_q} :
    (addr_i == scs_pkg::LOOP_CFG_OFS) ? {9'h0, loop_output_divider_field_q, loop_feedback_factor_field_q, loop_input_divider_field_q, 2'h0, osc_src_q,
                                         bypass_q} :
    (addr_i == scs_pkg::PRESC_OFS)    ? {22'h0, prescaler_divider_field_q} :
    (addr_i == scs_pkg::STATUS_OFS)   ? {28'h0, mode_q} :
    32'h0;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sel_q     <= scs_pkg::SEL_RST;
      bypass_q  <= scs_pkg::BYPASS_RST;
      osc_src_q <= scs_pkg::OSC_SRC_RST;
      loop_input_divider_field_q    <= scs_pkg::LOOP_INPUT_DIVIDER_FIELD_RST;
      loop_feedback_factor_field_q    <= scs_pkg::LOOP_FEEDBACK_FACTOR_FIELD_RST;
      loop_output_divider_field_q   <= scs_pkg::LOOP_OUTPUT_DIVIDER_FIELD_RST;
      prescaler_divider_field_q   <= scs_pkg::PRESCALER_DIVIDER_FIELD_RST;
    end else begin
      if (wr_sys) begin
        sel_q <= wr_data_i[1:0];
      end
      if (wr_loop) begin
        bypass_q  <= wr_data_i[scs_pkg::BYPASS_POS];
        osc_src_q <= wr_data_i[scs_pkg::OSC_SRC_POS];
        loop_input_divider_field_q    <= wr_data_i[scs_pkg::LOOP_INPUT_DIVIDER_FIELD_LSB +: scs_pkg::LOOP_INPUT_DIVIDER_FIELD_W];
        loop_feedback_factor_field_q    <= wr_data_i[scs_pkg::LOOP_FEEDBACK_FACTOR_FIELD_LSB +: scs_pkg::LOOP_FEEDBACK_FACTOR_FIELD_W];
        loop_output_divider_field_q   <= wr_data_i[scs_pkg::LOOP_OUTPUT_DIVIDER_FIELD_LSB +: scs_pkg::LOOP_OUTPUT_DIVIDER_FIELD_W];
      end
      if (wr_presc) begin
        prescaler_divider_field_q <= wr_data_i[PRESCALER_DIVIDER_FIELD_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      mode_q            <= scs_pkg::MODE_WAKE;
      cnt_q             <= 10'h000;
      osc_prev_q        <= 1'b0;
      sys_clk_o         <= 1'b0;
      loop_enable_o     <= 1'b0;
      loop_input_div_o  <= 5'h01;
      loop_feedback_o   <= 9'h001;
      loop_output_div_o <= 8'h01;
      rd_data_o         <= 32'h0;
    end else begin
      mode_q            <= mode_d;
      cnt_q             <= cnt_d;
      osc_prev_q        <= osc_lvl;
      sys_clk_o         <= sys_clk_d;
      loop_enable_o     <= (mode_d == scs_pkg::MODE_LOOP);
      loop_input_div_o  <= {1'b0, loop_input_divider_field_q} + 5'h01;
      loop_feedback_o   <= {1'b0, loop_feedback_factor_field_q} + 9'h001;
      loop_output_div_o <= {1'b0, loop_output_divider_field_q} + 8'h01;
      rd_data_o         <= rd_i ? rd_mux : 32'h0;
    end
  end

  // checks
  // every sampled source level shows on sys_clk_o one clock later, hence the $past terms
  // reset is disabled here, so the first edge after release only sees reset state

  chk_direct_follow: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    mode_q == scs_pkg::MODE_DIRECT |=> sys_clk_o == $past(direct_clock_i))
    else $error("direct mode does not follow the direct clock input");

  // select written with bypass already set; mode register follows one edge later
  chk_presc_select: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    bypass_q && wr_sys && wr_data_i[1:0] == scs_pkg::SEL_LOOP
      |=> ##1 mode_q == scs_pkg::MODE_PRESC)
    else $error("prescaler mode not entered");

  chk_mode_onehot: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $onehot(mode_q))
    else $error("mode register is not one-hot");

  chk_osc_source: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    mode_q == scs_pkg::MODE_PRESC && prescaler_divider_field_q == 10'h000 && osc_src_q
      |=> sys_clk_o == $past(internal_osc_i))
    else $error("prescaler not fed from the internal source");

  chk_factor_wrap: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    osc_rise && cnt_q == prescaler_divider_field_q |=> cnt_q == 10'h000)
    else $error("divider does not wrap at field plus one");

  chk_unit_pass: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    mode_q == scs_pkg::MODE_PRESC && prescaler_divider_field_q == 10'h000 && !osc_src_q
      |=> sys_clk_o == $past(crystal_input_pin_i))
    else $error("factor one does not pass the oscillator through");

  chk_factor_max: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (k1_fact <= scs_pkg::K1_FACT_MAX) and
    (prescaler_divider_field_q == 10'h3FF |-> k1_fact == scs_pkg::K1_FACT_MAX))
    else $error("largest prescaler factor is not 1024");

  chk_loop_enable: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    mode_q == scs_pkg::MODE_LOOP && $stable(mode_q) |-> loop_enable_o)
    else $error("loop not enabled in loop mode");

  // the loop must stay off in every other mode to save its supply current
  chk_loop_off: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    mode_q != scs_pkg::MODE_LOOP |-> !loop_enable_o)
    else $error("loop enabled outside loop mode");

  chk_loop_factor: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $stable(loop_feedback_factor_field_q) && !$past(sys_rst_i) |-> loop_feedback_o == {1'b0, loop_feedback_factor_field_q} + 9'h001)
    else $error("feedback factor is not field plus one");

  chk_loop_input: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $stable(loop_input_divider_field_q) && !$past(sys_rst_i) |-> loop_input_div_o == {1'b0, loop_input_divider_field_q} + 5'h01)
    else $error("input divider is not field plus one");

  chk_loop_output: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $stable(loop_output_divider_field_q) && !$past(sys_rst_i) |-> loop_output_div_o == {1'b0, loop_output_divider_field_q} + 8'h01)
    else $error("output divider is not field plus one");

  chk_wake_follow: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    mode_q == scs_pkg::MODE_WAKE |=> sys_clk_o == $past(wakeup_osc_i))
    else $error("wakeup mode does not follow the wakeup oscillator");

  // unassigned code must not leave the core without a clock
  chk_code_unused: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    sel_q == 2'h1 |=> mode_q == scs_pkg::MODE_WAKE)
    else $error("unassigned select code does not fall back to wakeup");

  chk_rd_presc: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    rd_i && addr_i == scs_pkg::PRESC_OFS |=> rd_data_o == {22'h0, $past(prescaler_divider_field_q)})
    else $error("prescaler field read back wrong");

  chk_rd_idle: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !rd_i |=> rd_data_o == 32'h0)
    else $error("read data not zero outside a read");

  cov_direct: cover property (@(posedge clk_i) mode_q == scs_pkg::MODE_DIRECT);

  cov_presc_wrap: cover property (@(posedge clk_i)
    mode_q == scs_pkg::MODE_PRESC && osc_rise && cnt_q == prescaler_divider_field_q && prescaler_divider_field_q != 10'h000);

  cov_presc_int: cover property (@(posedge clk_i)
    mode_q == scs_pkg::MODE_PRESC && prescaler_divider_field_q == 10'h000 && osc_src_q);

  cov_loop: cover property (@(posedge clk_i) loop_enable_o);

  cov_code_unused: cover property (@(posedge clk_i) sel_q == 2'h1);
endmodule // scs_top

/* bench/scs_osc_model.sv */
`timescale 1ns/100ps
module scs_osc_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] hi_i,
  input  wire logic [7:0] lo_i,
  output logic            osc_o
);
  int cnt_q = 0;
  initial osc_o = 1'b0;
  // free-running source; edges kept on the bench clock grid so levels never race sampling
  always @(posedge clk_i) begin
    cnt_q <= (cnt_q >= int'(hi_i) + int'(lo_i) - 1) ? 0 : cnt_q + 1;
    osc_o <= (cnt_q < int'(hi_i));
  end
endmodule // scs_osc_model

/* bench/test_system_clock_source_select.sv */
`timescale 1ns/100ps
module test_system_clock_source_select;
  logic        clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic [7:0]  addr_i = 8'h00;
  logic [31:0] wr_data_i = 32'h0;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic [31:0] rd_data_o;
  logic        dir_c, xtal_c, int_c, wu_c, loop_c, sys_clk_o, loop_enable_o;
  logic [4:0]  loop_input_div_o;
  logic [8:0]  loop_feedback_o;
  logic [7:0]  loop_output_div_o;
  logic [31:0] r;
  int          n_fail = 0;
  int          checks = 0;
  int          k;
  always #10 clk_i = ~clk_i;
  logic [7:0]  dir_hi = 8'h03, dir_lo = 8'h02, xt_hi = 8'h02, xt_lo = 8'h02;
  logic [7:0]  in_hi = 8'h05, in_lo = 8'h05, wu_hi = 8'h07, wu_lo = 8'h06;
  logic [7:0]  lp_hi = 8'h01, lp_lo = 8'h03;
  scs_osc_model u_dir (.clk_i(clk_i), .hi_i(dir_hi), .lo_i(dir_lo), .osc_o(dir_c));
  scs_osc_model u_xtal (.clk_i(clk_i), .hi_i(xt_hi), .lo_i(xt_lo), .osc_o(xtal_c));
  scs_osc_model u_int (.clk_i(clk_i), .hi_i(in_hi), .lo_i(in_lo), .osc_o(int_c));
  scs_osc_model u_wu (.clk_i(clk_i), .hi_i(wu_hi), .lo_i(wu_lo), .osc_o(wu_c));
  scs_osc_model u_loop (.clk_i(clk_i), .hi_i(lp_hi), .lo_i(lp_lo), .osc_o(loop_c));
  scs_top u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
    .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
    .direct_clock_i(dir_c), .crystal_input_pin_i(xtal_c), .internal_osc_i(int_c),
    .wakeup_osc_i(wu_c), .loop_clk_i(loop_c), .sys_clk_o(sys_clk_o),
    .loop_enable_o(loop_enable_o), .loop_input_div_o(loop_input_div_o),
    .loop_feedback_o(loop_feedback_o), .loop_output_div_o(loop_output_div_o));
  task automatic print_verdict();
    if (n_fail == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (exp !== got) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // strobe lowered then one idle edge, so no strobe is assigned twice in a step
  task automatic bus_wr(logic [7:0] a, logic [31:0] d);
    addr_i <= a;
    wr_data_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic bus_rd(logic [7:0] a, output logic [31:0] d);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    d = rd_data_o;
    @(posedge clk_i);
  endtask
  // skips one whole period first: a divider left mid-count gives a short first cycle
  task automatic meas(string what, int per, int hi);
    int t;
    int h;
    t = 0;
    h = 0;
    for (int ph = 0; ph < 6; ph++) begin
      while (sys_clk_o !== ph[0] && t < 20000) begin
        @(negedge clk_i);
        t++;
      end
      if (t >= 20000) begin
        n_fail++;
        print_verdict();
      end
      if (ph == 3) t = 0;
      if (ph == 4) h = t;
    end
    cmp(what, per, t);
    if (hi > 0) cmp(what, hi, h);
    @(posedge clk_i);
  endtask
  initial begin
    void'($urandom(21));
    repeat (20) @(posedge clk_i);
    @(negedge clk_i);
    cmp("rst loop_en", 32'h0, loop_enable_o);
    cmp("rst loop_input_divider_field", 32'h1, loop_input_div_o);
    cmp("rst loop_feedback_factor_field", 32'h1, loop_feedback_o);
    cmp("rst loop_output_divider_field", 32'h1, loop_output_div_o);
    @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    bus_rd(scs_pkg::SYS_CFG_OFS, r);
    cmp("sys_cfg", 32'h0, r);
    bus_rd(scs_pkg::LOOP_CFG_OFS, r);
    cmp("loop_cfg", 32'h1, r);
    bus_rd(8'h10, r);
    cmp("unmapped", 32'h0, r);
    bus_rd(scs_pkg::STATUS_OFS, r);
    cmp("status", 32'h1, r);
    meas("wake", 13, 7);
    bus_wr(scs_pkg::SYS_CFG_OFS, 32'h3);
    bus_rd(scs_pkg::STATUS_OFS, r);
    cmp("status", 32'h8, r);
    meas("direct", 5, 3);
    bus_wr(scs_pkg::LOOP_CFG_OFS, 32'h1);
    bus_wr(scs_pkg::SYS_CFG_OFS, 32'h2);
    bus_rd(scs_pkg::STATUS_OFS, r);
    cmp("status", 32'h4, r);
    cmp("loop_en", 32'h0, loop_enable_o);
    meas("xtal k1", 4, 2);
    bus_wr(scs_pkg::PRESC_OFS, 32'hFFFFFFFF);
    bus_rd(scs_pkg::PRESC_OFS, r);
    cmp("prescaler_divider_field", 32'h3FF, r);
    meas("k1 max", 4096, -1);
    bus_wr(scs_pkg::LOOP_CFG_OFS, 32'h3);
    k = 2 + $urandom_range(6);
    bus_wr(scs_pkg::PRESC_OFS, 32'(k - 1));
    meas("k1 int", 10 * k, -1);
    bus_wr(scs_pkg::PRESC_OFS, 32'h0);
    meas("int k1", 10, 5);
    r = $urandom() & 32'h007FFFF0;
    bus_wr(scs_pkg::LOOP_CFG_OFS, r);
    // outputs launched at the last edge are settled by the falling edge
    @(negedge clk_i);
    cmp("rd idle", 32'h0, rd_data_o);
    cmp("loop_en", 32'h1, loop_enable_o);
    cmp("loop_input_divider_field", {28'h0, r[7:4]} + 32'h1, loop_input_div_o);
    cmp("loop_feedback_factor_field", {24'h0, r[15:8]} + 32'h1, loop_feedback_o);
    cmp("loop_output_divider_field", {25'h0, r[22:16]} + 32'h1, loop_output_div_o);
    @(posedge clk_i);
    bus_rd(scs_pkg::STATUS_OFS, r);
    cmp("status", 32'h2, r);
    meas("loop", 4, 1);
    bus_wr(scs_pkg::SYS_CFG_OFS, 32'h1);
    bus_rd(scs_pkg::STATUS_OFS, r);
    cmp("status", 32'h1, r);
    print_verdict();
  end
endmodule // test_system_clock_source_select
